// >>> design/sctl_device.sv
// device end: serial shift register on the link clock, control registers and
// derived control levels on ref_clk_in
// assumes the host holds sclk still and sdata steady while load_strobe is high
`timescale 1ns/10ps
`include "sctl_params.svh"

module sctl_device
  import sctl_pkg::*;
(
  input  wire logic        ref_clk_in,           // core clock
  input  wire logic        rst_b_in,             // synchronous reset, active low
  input  wire logic        ce_in,                // clock enable for core state
  sctl_if.dev              link,                 // serial programming link
  input  wire logic        ref_in_in,            // reference input pin
  input  wire logic        lock_detect_in,       // digital lock detect level
  output logic             pd_polarity_out,      // 1 positive, 0 negative
  output logic             powered_down_out,     // software power-down active
  output logic             pump_tristate_out,    // charge pump high impedance
  output logic             divider_reset_out,    // dividers and band select in reset
  output logic             osc_enable_out,       // oscillator running
  output logic             lock_detect_reset_out,// lock detector held in reset
  output logic             bleed_enable_out,     // negative bleed current on
  output logic [7:0]       bleed_level_out,      // bleed magnitude
  output logic             feedback_source_out,  // 1 oscillator, 0 divider chain
  output logic [2:0]       output_divider_out,   // active output divider select
  output logic             main_enable_out,      // main output stage on
  output logic [1:0]       main_power_out,       // main output power level
  output logic             aux_enable_out,       // auxiliary output stage on
  output logic [1:0]       aux_power_out,        // auxiliary output power level
  output logic [1:0]       lock_count_out,       // in-window cycles before lock
  output logic             ref_loss_tolerant_out,// loss-of-lock mode
  output logic             lock_window_mode_out, // 1 fixed integer window
  output logic [15:0]      lock_window_ps_out    // comparison window in ps
);

  // ---------------- link domain ----------------
  sctl_word_t shift_q;  // serial shift register
  sctl_word_t shift_d;

  // shift in msb first on each rising link clock
  always_comb begin
    shift_d = {shift_q[30:0], link.sdata};
  end

  // no reset here: the link clock may stand still, and the word is
  // only read after a full frame has been clocked in
  always_ff @(posedge link.sclk) begin
    shift_q <= shift_d;
  end

  // ---------------- core domain: synchronisers ----------------
  logic [2:0] strobe_sync_q;   // [0] first stage, [2] edge history
  logic [2:0] strobe_sync_d;
  logic [2:0] ref_sync_q;      // reference input, same layout
  logic [2:0] ref_sync_d;
  logic [1:0] lock_sync_q;     // lock detect level
  logic [1:0] lock_sync_d;

  // two flops before any use; third flop only feeds the edge detector
  always_comb begin
    strobe_sync_d = {strobe_sync_q[1:0], link.load_strobe};
    ref_sync_d    = {ref_sync_q[1:0], ref_in_in};
    lock_sync_d   = {lock_sync_q[0], lock_detect_in};
  end

  // reset clears history so no false edge appears after release
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      strobe_sync_q <= 3'h0;
      ref_sync_q    <= 3'h0;
      lock_sync_q   <= 2'h0;
    end else if (ce_in) begin
      strobe_sync_q <= strobe_sync_d;
      ref_sync_q    <= ref_sync_d;
      lock_sync_q   <= lock_sync_d;
    end
  end

  logic strobe_rise;  // load strobe edge, synchronised
  logic ref_rise;     // reference rising edge, synchronised
  assign strobe_rise = strobe_sync_q[1] & ~strobe_sync_q[2];
  assign ref_rise    = ref_sync_q[1] & ~ref_sync_q[2];

  // ---------------- core domain: register bank ----------------
  sctl_word_t r4_q, r4_d;        // reference_and_pump_control
  sctl_word_t r6_q, r6_d;        // output_and_bleed_config
  sctl_word_t r7_q, r7_d;        // lock_detect_config
  sctl_word_t word_q, word_d;    // captured word awaiting load
  logic       pend_q, pend_d;    // a captured word is waiting
  logic [2:0] div_act_q, div_act_d; // active output divider
  logic       apply;             // load the captured word now
  sctl_sel_t  sel;               // select nibble of captured word

  assign sel = word_q[`SCTL_SEL_MSB:`SCTL_SEL_LSB];

  // capture the stable shift word on strobe, then apply either at once
  // or on the next reference rise when load sync is on
  always_comb begin
    word_d    = word_q;
    pend_d    = pend_q;
    r4_d      = r4_q;
    r6_d      = r6_q;
    r7_d      = r7_q;
    div_act_d = div_act_q;
    apply     = pend_q & (~r7_q[`SCTL_R7_LOAD_SYNC] | ref_rise);
    if (apply) begin
      pend_d = 1'b0;
      // registers keep accepting writes in power-down
      unique case (sel)
        `SCTL_SEL_R0: begin
          // register zero write releases the shadowed divider
          if (r4_q[`SCTL_R4_DBUF]) begin
            div_act_d = r6_q[`SCTL_R6_DIV_MSB:`SCTL_R6_DIV_LSB];
          end
        end
        `SCTL_SEL_REF_PUMP: begin
          r4_d = word_q;
        end
        `SCTL_SEL_OUT_BLEED: begin
          r6_d = word_q;
          // without double buffering the divider follows at once
          if (!r4_q[`SCTL_R4_DBUF]) begin
            div_act_d = word_q[`SCTL_R6_DIV_MSB:`SCTL_R6_DIV_LSB];
          end
        end
        `SCTL_SEL_LOCK_DET: begin
          r7_d = word_q;
        end
        default: begin
          // other selects belong to registers outside this bank,
          // fixed words included; they are accepted and dropped
        end
      endcase
    end
    // a new strobe wins over the apply that empties the slot
    if (strobe_rise) begin
      word_d = shift_q;
      pend_d = 1'b1;
    end
  end

  // power-down never touches these: contents are retained
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      r4_q      <= `SCTL_R4_RESET;
      r6_q      <= `SCTL_R6_RESET;
      r7_q      <= `SCTL_R7_RESET;
      word_q    <= 32'h0000_0000;
      pend_q    <= 1'b0;
      div_act_q <= 3'h0;
    end else if (ce_in) begin
      r4_q      <= r4_d;
      r6_q      <= r6_d;
      r7_q      <= r7_d;
      word_q    <= word_d;
      pend_q    <= pend_d;
      div_act_q <= div_act_d;
    end
  end

  // ---------------- core domain: derived controls ----------------
  logic        pd;        // software power-down
  logic        locked;    // lock seen and not held in reset
  logic [15:0] win_ps;    // selected comparison window
  logic [23:0] ctl_d;     // packed single-bit and small controls
  logic [23:0] ctl_q;
  logic [15:0] win_q;

  assign pd     = r4_q[`SCTL_R4_PWRDN];
  assign locked = lock_sync_q[1] & ~pd;

  // window in picoseconds from mode and precision
  always_comb begin
    unique case (r7_q[`SCTL_R7_WIN_MSB:`SCTL_R7_WIN_LSB])
      2'h0:    win_ps = `SCTL_WIN_5NS_PS;
      2'h1:    win_ps = `SCTL_WIN_6NS_PS;
      2'h2:    win_ps = `SCTL_WIN_8NS_PS;
      2'h3:    win_ps = `SCTL_WIN_12NS_PS;
    endcase
    if (r7_q[`SCTL_R7_WIN_MODE]) begin
      win_ps = `SCTL_WIN_INT_PS;
    end
  end

  // all control levels, packed so one flop stage feeds every output but bleed_level_out and lock_window_ps_out
  always_comb begin
    ctl_d[0]     = r4_q[`SCTL_R4_PD_POL];
    ctl_d[1]     = pd;
    ctl_d[2]     = r4_q[`SCTL_R4_TRISTATE] | pd;
    ctl_d[3]     = r4_q[`SCTL_R4_DIV_RST] | pd;
    ctl_d[4]     = ~pd;
    ctl_d[5]     = pd;
    // gated bleed only switches on once lock is reported
    ctl_d[6]     = r6_q[`SCTL_R6_NEG_BLEED] & (~r6_q[`SCTL_R6_GATED_BLEED] | locked);
    ctl_d[7]     = r6_q[`SCTL_R6_FB_SEL];
    ctl_d[8]     = r6_q[`SCTL_R6_MAIN_EN] & ~pd
                   & (~r6_q[`SCTL_R6_MUTE] | locked);
    ctl_d[9]     = r6_q[`SCTL_R6_AUX_EN] & ~pd
                   & (~r6_q[`SCTL_R6_MUTE] | locked);
    ctl_d[10]    = r7_q[`SCTL_R7_REF_LOSS];
    ctl_d[11]    = r7_q[`SCTL_R7_WIN_MODE];
    ctl_d[13:12] = r6_q[`SCTL_R6_MAIN_PWR_MSB:`SCTL_R6_MAIN_PWR_LSB];
    ctl_d[15:14] = r6_q[`SCTL_R6_AUX_PWR_MSB:`SCTL_R6_AUX_PWR_LSB];
    ctl_d[17:16] = r7_q[`SCTL_R7_CNT_MSB:`SCTL_R7_CNT_LSB];
    ctl_d[20:18] = div_act_q;
    ctl_d[23:21] = 3'h0;
  end

  // output stage; reset clears every control level to zero, oscillator enable included, and shows the 5 ns window
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ctl_q <= 24'h00_0000;
      win_q <= `SCTL_WIN_5NS_PS;
    end else if (ce_in) begin
      ctl_q <= ctl_d;
      win_q <= win_ps;
    end
  end

  logic [7:0] bleed_q;  // bleed magnitude, registered
  logic [7:0] bleed_d;
  always_comb begin
    bleed_d = r6_q[`SCTL_R6_BLEED_MSB:`SCTL_R6_BLEED_LSB];
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      bleed_q <= 8'h00;
    end else if (ce_in) begin
      bleed_q <= bleed_d;
    end
  end

  assign pd_polarity_out       = ctl_q[0];
  assign powered_down_out      = ctl_q[1];
  assign pump_tristate_out     = ctl_q[2];
  assign divider_reset_out     = ctl_q[3];
  assign osc_enable_out        = ctl_q[4];
  assign lock_detect_reset_out = ctl_q[5];
  assign bleed_enable_out      = ctl_q[6];
  assign feedback_source_out   = ctl_q[7];
  assign main_enable_out       = ctl_q[8];
  assign aux_enable_out        = ctl_q[9];
  assign ref_loss_tolerant_out = ctl_q[10];
  assign lock_window_mode_out  = ctl_q[11];
  assign main_power_out        = ctl_q[13:12];
  assign aux_power_out         = ctl_q[15:14];
  assign lock_count_out        = ctl_q[17:16];
  assign output_divider_out    = ctl_q[20:18];
  assign bleed_level_out       = bleed_q;
  assign lock_window_ps_out    = win_q;

endmodule // sctl_device

// >>> design/sctl_params.svh
// constants of the synthesizer control register bank: selects, field positions,
// reset values and link timing counts; included by package and both ends
`ifndef SCTL_PARAMS_SVH
`define SCTL_PARAMS_SVH

// register select codes, low four bits of each loaded word
`define SCTL_SEL_LSB        0
`define SCTL_SEL_MSB        3
`define SCTL_SEL_R0         4'h0
`define SCTL_SEL_REF_PUMP   4'h4
`define SCTL_SEL_FIXED_A    4'h5
`define SCTL_SEL_OUT_BLEED  4'h6
`define SCTL_SEL_LOCK_DET   4'h7
`define SCTL_SEL_FIXED_B    4'h8

// fixed words for the two fully reserved registers
`define SCTL_FIXED_A_WORD   32'h0080_0025
`define SCTL_FIXED_B_WORD   32'h102d_0428

// reference_and_pump_control fields
`define SCTL_R4_DBUF        14
`define SCTL_R4_PD_POL      7
`define SCTL_R4_PWRDN       6
`define SCTL_R4_TRISTATE    5
`define SCTL_R4_DIV_RST     4

// output_and_bleed_config fields
`define SCTL_R6_GATED_BLEED 30
`define SCTL_R6_NEG_BLEED   29
`define SCTL_R6_FB_SEL      24
`define SCTL_R6_DIV_MSB     23
`define SCTL_R6_DIV_LSB     21
`define SCTL_R6_BLEED_MSB   20
`define SCTL_R6_BLEED_LSB   13
`define SCTL_R6_MUTE        11
`define SCTL_R6_AUX_EN      9
`define SCTL_R6_AUX_PWR_MSB 8
`define SCTL_R6_AUX_PWR_LSB 7
`define SCTL_R6_MAIN_EN     6
`define SCTL_R6_MAIN_PWR_MSB 5
`define SCTL_R6_MAIN_PWR_LSB 4
// reserved bits of output_and_bleed_config: 31, 28:25 (1010), 12, 10
`define SCTL_R6_RSV_MASK    32'h9e00_1400
`define SCTL_R6_RSV_VALUE   32'h1400_0000

// lock_detect_config fields
`define SCTL_R7_LOAD_SYNC   25
`define SCTL_R7_CNT_MSB     9
`define SCTL_R7_CNT_LSB     8
`define SCTL_R7_REF_LOSS    7
`define SCTL_R7_WIN_MSB     6
`define SCTL_R7_WIN_LSB     5
`define SCTL_R7_WIN_MODE    4
// reserved bits of lock_detect_config: 31:26 (000100), 24:10 zero
`define SCTL_R7_RSV_MASK    32'hfdff_fc00
`define SCTL_R7_RSV_VALUE   32'h1000_0000

// reset values of the stored registers
`define SCTL_R4_RESET       32'h0000_0004
`define SCTL_R6_RESET       32'h1400_0006
`define SCTL_R7_RESET       32'h1000_0007

// lock comparison windows in picoseconds
`define SCTL_WIN_INT_PS     16'h0b54
`define SCTL_WIN_5NS_PS     16'h1388
`define SCTL_WIN_6NS_PS     16'h1770
`define SCTL_WIN_8NS_PS     16'h1f40
`define SCTL_WIN_12NS_PS    16'h2ee0

// host link timing, in reference clock cycles
`define SCTL_SCLK_HALF      4'h2
`define SCTL_STROBE_CYC     4'h8
`define SCTL_GAP_CYC        4'h4
`define SCTL_WORD_BITS      6'h20

`endif

// >>> design/sctl_pkg.sv
// types shared by both ends of the synthesizer control link
// assumes sctl_params.svh sits in the include path
`include "sctl_params.svh"

package sctl_pkg;

  typedef logic [31:0] sctl_word_t;   // one serial word
  typedef logic [3:0]  sctl_sel_t;    // register select code

  // host sequencer states, one-hot
  typedef enum logic [4:0] {
    SCTL_IDLE  = 5'b00001,
    SCTL_LOW   = 5'b00010,
    SCTL_HIGH  = 5'b00100,
    SCTL_LOAD  = 5'b01000,
    SCTL_GAP   = 5'b10000
  } sctl_host_state_t;

endpackage

// >>> design/sctl_if.sv
// three-wire serial programming link between host and synthesizer
// assumes the host drives every wire; the device only listens
`timescale 1ns/10ps

interface sctl_if;
  logic sclk;         // serial clock, idles low
  logic sdata;        // serial data, msb first
  logic load_strobe;  // rising edge loads the shifted word

  modport host (output sclk, output sdata, output load_strobe);
  modport dev  (input  sclk, input  sdata, input  load_strobe);
endinterface

// >>> design/sctl_host.sv
// host end: takes 32-bit words on a valid/ready port, forces reserved bits,
// shifts them out msb first on a divided clock and pulses the load strobe
// assumes the device samples sdata on the rising serial clock
`timescale 1ns/10ps
`include "sctl_params.svh"

module sctl_host
  import sctl_pkg::*;
(
  input  wire logic        ref_clk_in,     // core clock
  input  wire logic        rst_b_in,       // synchronous reset, active low
  input  wire logic        ce_in,          // clock enable
  input  wire logic        cmd_valid_in,   // word offered
  input  wire logic [31:0] cmd_word_in,    // word, low nibble selects register
  output logic             cmd_ready_out,  // word taken when valid and ready
  sctl_if.host             link            // serial programming link
);

  sctl_host_state_t state_q, state_d;  // sequencer
  sctl_word_t       word_q, word_d;    // word being sent
  logic [5:0]       bits_q, bits_d;    // bits left to send
  logic [3:0]       tick_q, tick_d;    // cycles left in current phase
  logic             sclk_q, sclk_d;
  logic             sdata_q, sdata_d;
  logic             stb_q, stb_d;
  logic             rdy_q, rdy_d;
  sctl_word_t       fixed;             // word with reserved bits forced

  // reserved patterns are forced here so callers cannot break them
  always_comb begin
    fixed = cmd_word_in;
    unique case (cmd_word_in[`SCTL_SEL_MSB:`SCTL_SEL_LSB])
      `SCTL_SEL_FIXED_A:   fixed = `SCTL_FIXED_A_WORD;
      `SCTL_SEL_OUT_BLEED: fixed = (cmd_word_in & ~`SCTL_R6_RSV_MASK)
                                   | `SCTL_R6_RSV_VALUE;
      `SCTL_SEL_LOCK_DET:  fixed = (cmd_word_in & ~`SCTL_R7_RSV_MASK)
                                   | `SCTL_R7_RSV_VALUE;
      `SCTL_SEL_FIXED_B:   fixed = `SCTL_FIXED_B_WORD;
      default:             fixed = cmd_word_in;
    endcase
  end

  // sequencer: data set while clock low, clock high half, then strobe
  always_comb begin
    state_d = state_q;
    word_d  = word_q;
    bits_d  = bits_q;
    tick_d  = tick_q;
    sclk_d  = sclk_q;
    sdata_d = sdata_q;
    stb_d   = stb_q;
    rdy_d   = rdy_q;
    unique case (state_q)
      SCTL_IDLE: begin
        if (cmd_valid_in && rdy_q) begin
          rdy_d   = 1'b0;
          word_d  = {fixed[30:0], 1'b0};
          sdata_d = fixed[31];
          bits_d  = `SCTL_WORD_BITS;
          tick_d  = `SCTL_SCLK_HALF;
          state_d = SCTL_LOW;
        end
      end
      SCTL_LOW: begin
        tick_d = tick_q - 4'h1;
        if (tick_q == 4'h1) begin
          sclk_d  = 1'b1;
          tick_d  = `SCTL_SCLK_HALF;
          bits_d  = bits_q - 6'h01;
          state_d = SCTL_HIGH;
        end
      end
      SCTL_HIGH: begin
        tick_d = tick_q - 4'h1;
        if (tick_q == 4'h1) begin
          sclk_d = 1'b0;
          tick_d = `SCTL_SCLK_HALF;
          if (bits_q == 6'h00) begin
            // clock falls low on the same edge the strobe rises
            stb_d   = 1'b1;
            tick_d  = `SCTL_STROBE_CYC;
            state_d = SCTL_LOAD;
          end else begin
            sdata_d = word_q[31];
            word_d  = {word_q[30:0], 1'b0};
            state_d = SCTL_LOW;
          end
        end
      end
      SCTL_LOAD: begin
        // long enough for the device's two-flop synchroniser
        tick_d = tick_q - 4'h1;
        if (tick_q == 4'h1) begin
          stb_d   = 1'b0;
          tick_d  = `SCTL_GAP_CYC;
          state_d = SCTL_GAP;
        end
      end
      SCTL_GAP: begin
        tick_d = tick_q - 4'h1;
        if (tick_q == 4'h1) begin
          rdy_d   = 1'b1;
          state_d = SCTL_IDLE;
        end
      end
      default: begin
        state_d = SCTL_IDLE;
      end
    endcase
  end

  // register stage; ce low freezes the whole link
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state_q <= SCTL_IDLE;
      word_q  <= 32'h0000_0000;
      bits_q  <= 6'h00;
      tick_q  <= 4'h0;
      sclk_q  <= 1'b0;
      sdata_q <= 1'b0;
      stb_q   <= 1'b0;
      rdy_q   <= 1'b1;
    end else if (ce_in) begin
      state_q <= state_d;
      word_q  <= word_d;
      bits_q  <= bits_d;
      tick_q  <= tick_d;
      sclk_q  <= sclk_d;
      sdata_q <= sdata_d;
      stb_q   <= stb_d;
      rdy_q   <= rdy_d;
    end
  end

  assign cmd_ready_out    = rdy_q;
  assign link.sclk        = sclk_q;
  assign link.sdata       = sdata_q;
  assign link.load_strobe = stb_q;

endmodule // sctl_host

// >>> test/sctl_checker.sv
// checker: wire timing of the serial link between host and device
// assumes host timing of two-cycle clock halves, 8-cycle strobe, 4-cycle gap
`timescale 1ns/10ps
`include "sctl_params.svh"

module sctl_checker (
  input wire logic ref_clk_in,  // core clock
  input wire logic rst_b_in,    // sync reset, active low
  input wire logic sclk,        // serial clock
  input wire logic sdata,       // serial data
  input wire logic load_strobe  // word load strobe
);
  logic       sclk_q;  // serial clock one cycle ago
  logic [5:0] rise_q;  // clock rises since last strobe
  logic [5:0] rise_d;  // next rise count

  // count serial clock rises; strobe clears so each frame counts alone
  always_comb begin
    rise_d = load_strobe ? 6'h00 : rise_q + {5'h00, sclk & ~sclk_q};
  end

  always_ff @(posedge ref_clk_in) begin
    sclk_q <= sclk;
    rise_q <= rst_b_in ? rise_d : 6'h00;
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence high_two;
    sclk [*2] ##1 !sclk;
  endsequence
  sequence strobe_eight;
    load_strobe [*8] ##1 !load_strobe;
  endsequence

  a_sclk_high_two: assert property ($rose(sclk) |-> high_two)
    else $error("serial clock high phase wrong");
  a_sclk_low_two: assert property ($fell(sclk) && !load_strobe |-> !sclk [*2])
    else $error("serial clock low phase short");
  a_strobe_width: assert property ($rose(load_strobe) |-> strobe_eight)
    else $error("strobe width wrong");
  a_quiet_strobe: assert property (load_strobe |-> !sclk)
    else $error("clock moved during strobe");
  a_data_steady: assert property (sclk |-> $stable(sdata))
    else $error("data moved while clock high");
  a_word_length: assert property ($rose(load_strobe) |-> rise_q == `SCTL_WORD_BITS)
    else $error("frame not 32 bits");
  a_gap_quiet: assert property ($fell(load_strobe) |-> !sclk [*4])
    else $error("gap after strobe short");
  a_rise_bound: assert property (rise_q <= `SCTL_WORD_BITS)
    else $error("too many clock rises");
endmodule // sctl_checker

// >>> test/synth_control_register_bank_bench.sv
// bench: host and device joined by the link; reset values, then frames
// assumes design/ is on the include path and both ends share ref clock
`timescale 1ns/10ps
`include "sctl_params.svh"

module synth_control_register_bank_bench import sctl_pkg::*; ;
  logic        clk = 1'b0;           // core clock, 4 ns
  logic        rst_b = 1'b0;         // reset, active low
  logic        vld = 1'b0;           // word offered
  logic        lock = 1'b0;          // lock detect level
  logic        refin = 1'b0;         // reference pin
  logic        rdy;                  // host ready
  logic        rdy_q = 1'b1;         // ready one edge ago
  sctl_word_t  word = 32'h0000_0000; // word offered
  sctl_word_t  sh;                   // word seen on the wire
  sctl_word_t  r4 = `SCTL_R4_RESET;  // model registers
  sctl_word_t  r6 = `SCTL_R6_RESET;
  sctl_word_t  r7 = `SCTL_R7_RESET;
  logic [2:0]  dv = 3'h0;            // model active divider
  logic [44:0] got;                  // device outputs packed
  logic [44:0] eq [$];               // expected outputs
  sctl_word_t  wq [$];               // expected wire words
  logic [3:0]  sels [8] = '{4'h4, 4'h6, 4'h7, 4'h0, 4'h5, 4'h8, 4'h3, 4'h6};
  logic [15:0] wins [4] = '{`SCTL_WIN_5NS_PS, `SCTL_WIN_6NS_PS, `SCTL_WIN_8NS_PS,
                            `SCTL_WIN_12NS_PS};
  int          error_cnt = 0;        // mismatches
  int          samples_checked = 0;  // comparisons
  logic        hung = 1'b0;          // a send ran out of time

  sctl_if sctl_if_inst ();

  sctl_host sctl_host_inst (.ref_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1),
    .cmd_valid_in(vld), .cmd_word_in(word), .cmd_ready_out(rdy), .link(sctl_if_inst.host));

  sctl_device sctl_device_inst (.ref_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1),
    .link(sctl_if_inst.dev), .ref_in_in(refin), .lock_detect_in(lock),
    .pd_polarity_out(got[44]), .powered_down_out(got[43]), .pump_tristate_out(got[42]),
    .divider_reset_out(got[41]), .osc_enable_out(got[40]), .lock_detect_reset_out(got[39]),
    .bleed_enable_out(got[38]), .bleed_level_out(got[37:30]), .feedback_source_out(got[29]),
    .output_divider_out(got[28:26]), .main_enable_out(got[25]), .main_power_out(got[24:23]),
    .aux_enable_out(got[22]), .aux_power_out(got[21:20]), .lock_count_out(got[19:18]),
    .ref_loss_tolerant_out(got[17]), .lock_window_mode_out(got[16]),
    .lock_window_ps_out(got[15:0]));

  sctl_checker sctl_checker_inst (.ref_clk_in(clk), .rst_b_in(rst_b),
    .sclk(sctl_if_inst.sclk), .sdata(sctl_if_inst.sdata),
    .load_strobe(sctl_if_inst.load_strobe));

  // clocks; reference runs slow so load sync waits a few cycles
  initial begin
    forever #2 clk = ~clk;
  end
  always begin
    repeat (3) @(posedge clk);
    #1 refin = ~refin;
  end

  // expected outputs from model registers and lock level
  function automatic logic [44:0] model(input logic lk);
    logic p;
    logic l;
    p = r4[6];
    l = lk & ~p;
    return {r4[7], p, r4[5] | p, r4[4] | p, ~p, p,
      r6[29] & (~r6[30] | l), r6[20:13], r6[24], dv,
      r6[6] & ~p & (~r6[11] | l), r6[5:4], r6[9] & ~p & (~r6[11] | l), r6[8:7],
      r7[9:8], r7[7], r7[4], r7[4] ? `SCTL_WIN_INT_PS : wins[r7[6:5]]};
  endfunction

  task automatic chk(input logic [44:0] e, input logic [44:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // offer a word, wait for take, then note the wire and output results
  task automatic send(input sctl_word_t w);
    sctl_word_t f;
    int n;
    vld = 1'b1;
    word = w;
    n = 0;
    // ready is looked at settled, after the edge; the next edge takes
    while (rdy !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 400) begin
      error_cnt++;
      hung = 1'b1;
      return;
    end
    @(posedge clk);
    #1 lock = ($urandom & 1) != 0;
    f = w;
    case (w[3:0])
      `SCTL_SEL_FIXED_A: f = `SCTL_FIXED_A_WORD;
      `SCTL_SEL_FIXED_B: f = `SCTL_FIXED_B_WORD;
      `SCTL_SEL_OUT_BLEED: f = w & ~`SCTL_R6_RSV_MASK | `SCTL_R6_RSV_VALUE;
      `SCTL_SEL_LOCK_DET: f = w & ~`SCTL_R7_RSV_MASK | `SCTL_R7_RSV_VALUE;
      default: ;
    endcase
    if (f[3:0] == `SCTL_SEL_REF_PUMP) r4 = f;
    if (f[3:0] == `SCTL_SEL_OUT_BLEED) r6 = f;
    if (f[3:0] == `SCTL_SEL_LOCK_DET) r7 = f;
    if ((f[3:0] == `SCTL_SEL_OUT_BLEED && !r4[14]) || (f[3:0] == 4'h0 && r4[14])) dv = r6[23:21];
    wq.push_back(f);
    eq.push_back(model(lock));
  endtask

  // watcher: wire word at each strobe, outputs at each frame end
  always @(posedge sctl_if_inst.sclk) sh = {sh[30:0], sctl_if_inst.sdata};
  always @(posedge sctl_if_inst.load_strobe) begin
    if (wq.size() > 0) chk({13'h0000, wq.pop_front()}, {13'h0000, sh});
  end
  // looked at 1 ns after the edge so ready and outputs have settled
  always @(posedge clk) begin
    #1;
    if (rdy && !rdy_q && eq.size() > 0) chk(eq.pop_front(), got);
    rdy_q = rdy;
  end

  initial begin
    sctl_word_t w;
    void'($urandom(32'hc5c65376));
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(model(1'b0), got);
    $display("test reset done");
    // back to back frames; each window code and select is hit
    for (int i = 0; i < 48 && !hung; i++) begin
      w = $urandom;
      w[3:0] = sels[i % 8];
      if (i % 8 == 2) w[6:4] = (i == 34) ? 3'h1 : {2'(i / 8), 1'b0};
      send(w);
    end
    vld = 1'b0;
    for (int n = 0; n < 400 && eq.size() + wq.size() > 0; n++) @(posedge clk);
    if (eq.size() + wq.size() > 0) error_cnt++;
    $display("test frames done");
    summarize();
  end
endmodule // synth_control_register_bank_bench
